// file: include/dtc_params.svh
// offsets, bit positions, reset values and timing counts of the dynamic threshold control block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// register word indexes (8-bit map, word index times four on the bus)
`define DTC_IDX_CTRL1        8'h36
`define DTC_IDX_CYC_LO       8'h37
`define DTC_IDX_OP_R1        8'h33
`define DTC_IDX_OP_LOC       8'h34
`define DTC_IDX_OP_R2        8'h35
`define DTC_IDX_STATUS       8'h80
`define DTC_IDX_MASK         8'h81
`define DTC_IDX_LOCK         8'h82
`define DTC_IDX_MIN_FAN_ON_TEMPERATURE_R1      8'h83
`define DTC_IDX_MIN_FAN_ON_TEMPERATURE_LOC     8'h84
`define DTC_IDX_MIN_FAN_ON_TEMPERATURE_R2      8'h85

// control register one fields
`define DTC_BIT_CYC_MSB      0
`define DTC_BIT_VLOW_POLICY  1
`define DTC_BIT_CAP_R1       2
`define DTC_BIT_CAP_LOC      3
`define DTC_BIT_CAP_R2       4
`define DTC_BIT_DYN_R1       5
`define DTC_BIT_DYN_LOC      6
`define DTC_BIT_DYN_R2       7

// status / mask fields
`define DTC_ST_VLOW          1
`define DTC_ST_CAPTURE       2

// reset values
`define DTC_RST_CTRL1        8'h00
`define DTC_RST_CYC_LO       8'h00
`define DTC_RST_OP           8'h64
`define DTC_RST_MIN_FAN_ON_TEMPERATURE         8'h5a

// decrease interval base, increase is twice it
`define DTC_DEC_BASE         12'h004
`define DTC_INC_BASE         12'h008

`endif

// file: include/dtc_pkg.sv
// types shared by the dynamic threshold control block
package dtc_pkg;

  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } dtc_temps_s;

  typedef struct packed {
    logic remote2_dynamic_enable;
    logic local_dynamic_enable;
    logic remote1_dynamic_enable;
    logic remote2_capture_on_limit;
    logic local_capture_on_limit;
    logic remote1_capture_on_limit;
    logic core_voltage_low_policy;
    logic remote2_cycle_code_msb;
  } dtc_ctrl1_s;

  typedef enum logic [1:0] {
    DTC_WAIT,
    DTC_DEC,
    DTC_INC
  } dtc_step_e;

endpackage

// file: hdl/dtc_loop.sv
// per-channel minimum fan-on temperature adjuster with cycle-code pacing
`timescale 1ns/100ps
`default_nettype none
`include "dtc_params.svh"

module dtc_loop #(
  parameter int unsigned CW = 12
) (
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_i,      // sync reset
  input  wire logic       tick_i,     // one monitoring cycle
  input  wire logic       enable_i,   // dynamic control on
  input  wire logic [2:0] code_i,     // cycle code
  input  wire logic [7:0] temp_i,     // current temperature
  input  wire logic [7:0] op_i,       // operating point
  input  wire logic [7:0] hi_i,       // high limit
  input  wire logic [7:0] lo_i,       // low limit
  input  wire logic       wr_i,       // software write of threshold
  input  wire logic [7:0] wdata_i,    // written threshold
  output logic      [7:0] min_fan_on_temperature_o      // minimum fan-on temperature
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] dec_len;
  logic [CW-1:0] inc_len;
  dtc_pkg::dtc_step_e step;

  // cycle code n gives 4*2^n and 8*2^n monitoring cycles
  assign dec_len = CW'(`DTC_DEC_BASE) << code_i;
  assign inc_len = CW'(`DTC_INC_BASE) << code_i;

  always_comb
  begin
    if ($signed(temp_i) > $signed(op_i) && min_fan_on_temperature_o > lo_i)
      step = dtc_pkg::DTC_DEC;
    else if ($signed(temp_i) < $signed(op_i) && min_fan_on_temperature_o < hi_i)
      step = dtc_pkg::DTC_INC;
    else
      step = dtc_pkg::DTC_WAIT;
  end

  // the counter restarts while idle so a fresh enable waits a full interval
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable_i)
      cnt <= '0;
    else if (tick_i)
    begin
      case (step)
        dtc_pkg::DTC_DEC: cnt <= (cnt + 1'b1 >= dec_len) ? '0 : cnt + 1'b1;
        dtc_pkg::DTC_INC: cnt <= (cnt + 1'b1 >= inc_len) ? '0 : cnt + 1'b1;
        default:          cnt <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      min_fan_on_temperature_o <= `DTC_RST_MIN_FAN_ON_TEMPERATURE;
    else if (wr_i)
      min_fan_on_temperature_o <= wdata_i;
    else if (enable_i && tick_i)
    begin
      case (step)
        dtc_pkg::DTC_DEC:
          if (cnt + 1'b1 >= dec_len)
            min_fan_on_temperature_o <= min_fan_on_temperature_o - 8'h01;
        dtc_pkg::DTC_INC:
          if (cnt + 1'b1 >= inc_len)
            min_fan_on_temperature_o <= min_fan_on_temperature_o + 8'h01;
        default: ;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hdl/dtc_top.sv
// dynamic threshold control register one with wishbone slave and capture logic
//
// What this block does
// - bit 0 holds the top bit of the remote 2 cycle code, the lower two come from the companion register.
// - the remote 2 cycle code paces how many monitoring cycles pass between threshold steps.
// - code n gives a decrease interval of 4*2^n and an increase interval of 8*2^n monitoring cycles.
// - with bit 1 set, on standby supply and core voltage under its low limit, low-voltage actions apply.
// - low-voltage actions set status bit 1 and raise the alert output when enabled.
// - low-voltage actions stop hot monitoring, dynamic control and shutdown entry until voltage recovers.
// - bit 2 copies remote 1 temperature into its operating point when the limit pin asserts.
// - bit 3 copies local temperature into its operating point when the limit pin asserts.
// - bit 4 copies remote 2 temperature into its operating point when the limit pin asserts.
// - with a capture bit clear, the pin is ignored and the operating point keeps its programmed value.
// - bit 5 enables dynamic threshold control on remote 1.
// - bit 6 enables dynamic threshold control on the local channel.
// - bit 7 enables dynamic threshold control on remote 2.
// - an enabled channel adjusts its threshold from temperature, operating point and limits.
// - a disabled channel keeps its programmed threshold under ordinary automatic control.
// - once the lock bit is set the register ignores every later write.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_params.svh"

module dtc_top #(
  parameter int unsigned TICK_DIV = 16
) (
  input  wire logic               clk_i,           // 100 MHz clock
  input  wire logic               rst_i,           // sync reset, high
  input  wire logic [9:0]         adr_i,           // wishbone byte address
  input  wire logic [31:0]        dat_i,           // wishbone write data
  output logic      [31:0]        dat_o,           // wishbone read data
  input  wire logic               we_i,            // write enable
  input  wire logic [3:0]         sel_i,           // byte selects
  input  wire logic               cyc_i,           // bus cycle
  input  wire logic               stb_i,           // strobe
  output logic                    ack_o,           // acknowledge
  input  wire logic               thermal_limit_n_i, // limit pin, low active
  input  wire logic               standby_supply_i,  // running from standby rail
  input  wire logic [7:0]         core_voltage_i,    // core voltage reading
  input  wire logic [7:0]         core_low_limit_i,  // core voltage low limit
  input  wire logic               alert_enable_i,    // alert output enabled
  input  wire dtc_pkg::dtc_temps_s temps_i,        // current temperatures
  input  wire dtc_pkg::dtc_temps_s hi_lim_i,       // high limits
  input  wire dtc_pkg::dtc_temps_s lo_lim_i,       // low limits
  output logic                    alert_n_o,       // alert output, low active
  output logic                    hot_mon_en_o,    // processor hot monitoring allowed
  output logic                    shutdown_ok_o,   // shutdown entry allowed
  output logic                    irq_o,           // interrupt level
  output dtc_pkg::dtc_temps_s     min_fan_on_temperature_o,          // thresholds
  output dtc_pkg::dtc_temps_s     op_point_o       // operating points
);

  dtc_pkg::dtc_ctrl1_s ctrl1;
  logic [7:0]  cyc_lo;
  logic [7:0]  status;
  logic [7:0]  mask;
  logic        lock;
  logic [7:0]  idx;
  logic        wr;
  logic        rd;
  logic        limit_s1;
  logic        limit_s2;
  logic        limit_d;
  logic        limit_rise;
  logic        vlow;
  logic        vlow_d;
  logic [15:0] tick_cnt;
  logic        tick;
  logic [2:0]  dyn_en;
  logic [2:0]  code [3];
  logic [2:0]  min_fan_on_temperature_wr;
  logic [23:0] min_fan_on_temperature_flat;
  logic [23:0] temp_flat;
  logic [23:0] hi_flat;
  logic [23:0] lo_flat;
  logic [23:0] op_flat;

  //--------------------------------------------------------------
  // wishbone slave
  //--------------------------------------------------------------
  assign idx = adr_i[9:2];
  assign wr  = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd  = cyc_i && stb_i && !we_i && !ack_o;

  // one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  // unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      case (idx)
        `DTC_IDX_CTRL1:    dat_o <= {24'h000000, ctrl1};
        `DTC_IDX_CYC_LO:   dat_o <= {24'h000000, cyc_lo};
        `DTC_IDX_OP_R1:    dat_o <= {24'h000000, op_point_o.remote1};
        `DTC_IDX_OP_LOC:   dat_o <= {24'h000000, op_point_o.local_t};
        `DTC_IDX_OP_R2:    dat_o <= {24'h000000, op_point_o.remote2};
        `DTC_IDX_STATUS:   dat_o <= {24'h000000, status};
        `DTC_IDX_MASK:     dat_o <= {24'h000000, mask};
        `DTC_IDX_LOCK:     dat_o <= {31'h00000000, lock};
        `DTC_IDX_MIN_FAN_ON_TEMPERATURE_R1:  dat_o <= {24'h000000, min_fan_on_temperature_o.remote1};
        `DTC_IDX_MIN_FAN_ON_TEMPERATURE_LOC: dat_o <= {24'h000000, min_fan_on_temperature_o.local_t};
        `DTC_IDX_MIN_FAN_ON_TEMPERATURE_R2:  dat_o <= {24'h000000, min_fan_on_temperature_o.remote2};
        default:           dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //--------------------------------------------------------------
  // control registers and lock
  //--------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lock <= 1'b0;
    else if (wr && idx == `DTC_IDX_LOCK && dat_i[0])
      lock <= 1'b1;
  end

  // lock is sticky until reset, so nothing can reopen the register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl1 <= `DTC_RST_CTRL1;
    else if (wr && idx == `DTC_IDX_CTRL1 && !lock)
      ctrl1 <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cyc_lo <= `DTC_RST_CYC_LO;
    else if (wr && idx == `DTC_IDX_CYC_LO && !lock)
      cyc_lo <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask <= 8'h00;
    else if (wr && idx == `DTC_IDX_MASK)
      mask <= dat_i[7:0];
  end

  //--------------------------------------------------------------
  // limit pin sync and edge
  //--------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      limit_s1 <= 1'b0;
      limit_s2 <= 1'b0;
      limit_d  <= 1'b0;
    end
    else
    begin
      limit_s1 <= !thermal_limit_n_i;
      limit_s2 <= limit_s1;
      limit_d  <= limit_s2;
    end
  end

  assign limit_rise = limit_s2 && !limit_d;

  //--------------------------------------------------------------
  // operating points with capture
  //--------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      op_point_o <= {`DTC_RST_OP, `DTC_RST_OP, `DTC_RST_OP};
    else
    begin
      if (limit_rise && ctrl1.remote1_capture_on_limit)
        op_point_o.remote1 <= temps_i.remote1;
      else if (wr && idx == `DTC_IDX_OP_R1 && !lock)
        op_point_o.remote1 <= dat_i[7:0];
      if (limit_rise && ctrl1.local_capture_on_limit)
        op_point_o.local_t <= temps_i.local_t;
      else if (wr && idx == `DTC_IDX_OP_LOC && !lock)
        op_point_o.local_t <= dat_i[7:0];
      if (limit_rise && ctrl1.remote2_capture_on_limit)
        op_point_o.remote2 <= temps_i.remote2;
      else if (wr && idx == `DTC_IDX_OP_R2 && !lock)
        op_point_o.remote2 <= dat_i[7:0];
    end
  end

  //--------------------------------------------------------------
  // low core voltage policy
  //--------------------------------------------------------------
  assign vlow = ctrl1.core_voltage_low_policy && standby_supply_i
                && core_voltage_i < core_low_limit_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vlow_d <= 1'b0;
    else
      vlow_d <= vlow;
  end

  assign hot_mon_en_o  = !vlow_d;
  assign shutdown_ok_o = !vlow_d;

  //--------------------------------------------------------------
  // sticky status, set wins over write-one clear
  //--------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 8'h00;
    else
    begin
      for (int b = 0; b < 8; b++)
      begin
        // set from the live condition so the flag lands with the outputs
        if (b == `DTC_ST_VLOW && vlow)
          status[b] <= 1'b1;
        else if (b == `DTC_ST_CAPTURE && limit_rise && ctrl1[4:2] != 3'b000)
          status[b] <= 1'b1;
        else if (wr && idx == `DTC_IDX_STATUS && dat_i[b])
          status[b] <= 1'b0;
      end
    end
  end

  assign irq_o = |(status & mask);
  // alert follows the registered low-voltage condition (vlow_d) while enabled
  assign alert_n_o = !(vlow_d && alert_enable_i);

  //--------------------------------------------------------------
  // monitoring cycle tick and per-channel loops
  //--------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick_cnt == 16'(TICK_DIV - 1))
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  assign tick = (tick_cnt == 16'(TICK_DIV - 1));

  // low voltage suspends every loop
  assign dyn_en = {ctrl1.remote2_dynamic_enable,
                   ctrl1.local_dynamic_enable,
                   ctrl1.remote1_dynamic_enable}
                  & {3{!vlow_d}};

  // remote 2 code spans two registers
  assign code[2] = {ctrl1.remote2_cycle_code_msb, cyc_lo[7:6]};
  assign code[1] = cyc_lo[5:3];
  assign code[0] = 3'h0;

  assign temp_flat = {temps_i.remote2, temps_i.local_t, temps_i.remote1};
  assign hi_flat   = {hi_lim_i.remote2, hi_lim_i.local_t, hi_lim_i.remote1};
  assign lo_flat   = {lo_lim_i.remote2, lo_lim_i.local_t, lo_lim_i.remote1};
  assign op_flat   = {op_point_o.remote2, op_point_o.local_t, op_point_o.remote1};
  assign min_fan_on_temperature_wr[0] = wr && idx == `DTC_IDX_MIN_FAN_ON_TEMPERATURE_R1 && !lock;
  assign min_fan_on_temperature_wr[1] = wr && idx == `DTC_IDX_MIN_FAN_ON_TEMPERATURE_LOC && !lock;
  assign min_fan_on_temperature_wr[2] = wr && idx == `DTC_IDX_MIN_FAN_ON_TEMPERATURE_R2 && !lock;

  for (genvar ch = 0; ch < 3; ch++)
  begin : g_loop
    dtc_loop #(
      .CW       (12)
    ) u_loop (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .tick_i   (tick),
      .enable_i (dyn_en[ch]),
      .code_i   (code[ch]),
      .temp_i   (temp_flat[ch*8 +: 8]),
      .op_i     (op_flat[ch*8 +: 8]),
      .hi_i     (hi_flat[ch*8 +: 8]),
      .lo_i     (lo_flat[ch*8 +: 8]),
      .wr_i     (min_fan_on_temperature_wr[ch]),
      .wdata_i  (dat_i[7:0]),
      .min_fan_on_temperature_o   (min_fan_on_temperature_flat[ch*8 +: 8])
    );
  end

  assign min_fan_on_temperature_o = {min_fan_on_temperature_flat[7:0], min_fan_on_temperature_flat[15:8], min_fan_on_temperature_flat[23:16]};

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  sequence s_rise;
    limit_s2 && !limit_d;
  endsequence

  lock_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lock && wr && idx == `DTC_IDX_CTRL1 |=> $stable(ctrl1))
    else $error("locked register changed");

  cap_r1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise and ctrl1.remote1_capture_on_limit |=> op_point_o.remote1 == $past(temps_i.remote1))
    else $error("remote 1 capture missed");

  cap_loc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise and ctrl1.local_capture_on_limit |=> op_point_o.local_t == $past(temps_i.local_t))
    else $error("local capture missed");

  cap_r2_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise and ctrl1.remote2_capture_on_limit |=> op_point_o.remote2 == $past(temps_i.remote2))
    else $error("remote 2 capture missed");

  cap_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl1.remote1_capture_on_limit && !(wr && idx == `DTC_IDX_OP_R1) |=> $stable(op_point_o.remote1))
    else $error("remote 1 point moved without capture");

  cap_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    limit_rise |=> !limit_rise)
    else $error("capture edge repeated");

  vlow_act_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vlow |=> status[`DTC_ST_VLOW] && !hot_mon_en_o && !shutdown_ok_o)
    else $error("low voltage actions missing");

  vlow_alert_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vlow |=> alert_n_o != alert_enable_i)
    else $error("alert not raised");

  vlow_dyn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vlow |=> dyn_en == 3'b000)
    else $error("dynamic control not suspended");

  dyn_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !dyn_en[2] && !min_fan_on_temperature_wr[2] |=> $stable(min_fan_on_temperature_o.remote2))
    else $error("disabled threshold changed");

endmodule

`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the dynamic threshold control register block
`timescale 1ns/100ps
`default_nettype none
`include "dtc_params.svh"

module testbench;
  localparam int TD = 4;
  logic                clk_i;
  logic                rst_i;
  logic [9:0]          adr_i;
  logic [31:0]         dat_i;
  logic [31:0]         dat_o;
  logic                we_i;
  logic [3:0]          sel_i;
  logic                cyc_i;
  logic                stb_i;
  logic                ack_o;
  logic                thermal_limit_n_i;
  logic                standby_supply_i;
  logic [7:0]          core_voltage_i;
  logic [7:0]          core_low_limit_i;
  logic                alert_enable_i;
  dtc_pkg::dtc_temps_s temps_i;
  dtc_pkg::dtc_temps_s hi_lim_i;
  dtc_pkg::dtc_temps_s lo_lim_i;
  logic                alert_n_o;
  logic                hot_mon_en_o;
  logic                shutdown_ok_o;
  logic                irq_o;
  dtc_pkg::dtc_temps_s min_fan_on_temperature_o;
  dtc_pkg::dtc_temps_s op_point_o;
  logic                probe_req;
  logic [31:0]         seen;
  logic [31:0]         exp_q[$];
  logic [7:0]          r1;
  logic [7:0]          r2;
  int                  err_total;
  int                  checks_done;
  int                  seed;
  int                  n;

  dtc_top #(.TICK_DIV(TD)) dtc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .thermal_limit_n_i(thermal_limit_n_i), .standby_supply_i(standby_supply_i),
    .core_voltage_i(core_voltage_i), .core_low_limit_i(core_low_limit_i),
    .alert_enable_i(alert_enable_i), .temps_i(temps_i), .hi_lim_i(hi_lim_i),
    .lo_lim_i(lo_lim_i), .alert_n_o(alert_n_o), .hot_mon_en_o(hot_mon_en_o),
    .shutdown_ok_o(shutdown_ok_o), .irq_o(irq_o), .min_fan_on_temperature_o(min_fan_on_temperature_o), .op_point_o(op_point_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, got, want);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask

  // results are compared in arrival order against the oldest note
  always @(posedge clk_i)
  begin
    if ((ack_o === 1'b1 && we_i === 1'b0) || probe_req === 1'b1)
    begin
      seen = probe_req ? {28'h0, alert_n_o, hot_mon_en_o, shutdown_ok_o, irq_o} : dat_o;
      if (exp_q.size() == 0)
        give_up();
      else
        check(seen, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // bus and probe drivers
  // ----------------------------------------------------------------
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    if (k >= 50)
      give_up();
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] want);
    exp_q.push_back({24'h0, want});
    wb(idx, 1'b0, 8'h00);
  endtask

  // expected {alert_n, hot_mon_en, shutdown_ok, irq}
  task automatic probe(input logic [3:0] want);
    exp_q.push_back({28'h0, want});
    @(posedge clk_i);
    probe_req <= 1'b1;
    @(posedge clk_i);
    probe_req <= 1'b0;
  endtask

  // clocks until the remote 2 threshold next moves
  task automatic next_step(output int cnt);
    logic [7:0] last;
    last = min_fan_on_temperature_o.remote2;
    cnt = 0;
    while (min_fan_on_temperature_o.remote2 === last && cnt < 5000)
    begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 5000)
      give_up();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h839a12cd;
    err_total = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, probe_req} = 4'h0;
    sel_i = 4'h0;
    adr_i = 10'h000;
    dat_i = 32'h0;
    thermal_limit_n_i = 1'b1;
    standby_supply_i = 1'b0;
    core_voltage_i = 8'h80;
    core_low_limit_i = 8'h20;
    alert_enable_i = 1'b1;
    temps_i = {3{8'h30}};
    hi_lim_i = {3{8'h7f}};
    lo_lim_i = {3{8'h00}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`DTC_IDX_CTRL1, `DTC_RST_CTRL1);
    rd(`DTC_IDX_OP_LOC, `DTC_RST_OP);
    rd(`DTC_IDX_MIN_FAN_ON_TEMPERATURE_R2, `DTC_RST_MIN_FAN_ON_TEMPERATURE);
    rd(8'h10, 8'h00);
    r1 = 8'($random(seed));
    wr(`DTC_IDX_CTRL1, r1);
    rd(`DTC_IDX_CTRL1, r1);
    // capture on all three channels
    wr(`DTC_IDX_CTRL1, 8'h1c);
    r1 = 8'($random(seed)) & 8'h7f;
    r2 = 8'($random(seed)) & 8'h7f;
    @(posedge clk_i);
    temps_i <= {r1, 8'h22, r2};
    thermal_limit_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    temps_i <= {3{8'h11}};
    repeat (20) @(posedge clk_i);
    rd(`DTC_IDX_OP_R1, r1);
    rd(`DTC_IDX_OP_LOC, 8'h22);
    rd(`DTC_IDX_OP_R2, r2);
    rd(`DTC_IDX_OP_R1, r1);
    thermal_limit_n_i <= 1'b1;
    wr(`DTC_IDX_CTRL1, 8'h00);
    repeat (4) @(posedge clk_i);
    thermal_limit_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(`DTC_IDX_OP_R1, r1);
    rd(`DTC_IDX_OP_LOC, 8'h22);
    thermal_limit_n_i <= 1'b1;
    wr(`DTC_IDX_STATUS, 8'hff);
    // low core voltage on standby, policy off then on
    standby_supply_i <= 1'b1;
    core_voltage_i <= 8'h10;
    repeat (4) @(posedge clk_i);
    probe(4'b1110);
    wr(`DTC_IDX_CTRL1, 8'h02);
    repeat (4) @(posedge clk_i);
    probe(4'b0000);
    rd(`DTC_IDX_STATUS, 8'h02);
    wr(`DTC_IDX_MASK, 8'h02);
    probe(4'b0001);
    // alert stays quiet while disabled
    alert_enable_i <= 1'b0;
    probe(4'b1001);
    alert_enable_i <= 1'b1;
    core_voltage_i <= 8'h30;
    repeat (4) @(posedge clk_i);
    probe(4'b1111);
    wr(`DTC_IDX_STATUS, 8'h02);
    probe(4'b1110);
    // remote 2 pacing: decrease then increase, two codes
    wr(`DTC_IDX_OP_R2, 8'h64);
    wr(`DTC_IDX_CYC_LO, 8'h00);
    @(posedge clk_i);
    temps_i <= {8'h30, 8'h30, 8'h70};
    wr(`DTC_IDX_CTRL1, 8'h80);
    next_step(n);
    next_step(n);
    check(32'(n), 32'(4 * TD));
    r2 = min_fan_on_temperature_o.remote2;
    next_step(n);
    check({31'h0, min_fan_on_temperature_o.remote2 < r2}, 32'h1);
    wr(`DTC_IDX_CTRL1, 8'h81);
    next_step(n);
    next_step(n);
    check(32'(n), 32'(64 * TD));
    wr(`DTC_IDX_CTRL1, 8'h80);
    @(posedge clk_i);
    temps_i <= {8'h30, 8'h30, 8'h08};
    next_step(n);
    next_step(n);
    check(32'(n), 32'(8 * TD));
    check({24'h0, min_fan_on_temperature_o.remote1}, {24'h0, `DTC_RST_MIN_FAN_ON_TEMPERATURE});
    // lock makes the register read-only
    wr(`DTC_IDX_LOCK, 8'h01);
    wr(`DTC_IDX_CTRL1, 8'h5a);
    rd(`DTC_IDX_CTRL1, 8'h80);
    repeat (4) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
    print_verdict();
  end

  initial
  begin
    #900000;
    give_up();
  end
endmodule

`default_nettype wire
